// file: src/svw_pkg.sv
package svw_pkg;

  // Clock and timebase
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int PRE_W = 24;

  // Watchdog period and reset stretch, in ms and in ticks
  localparam int WD_PERIOD_MS = 1600;
  localparam int RST_SHORT_MS = 50;
  localparam int RST_LONG_MS = 200;
  localparam int WD_TICKS = WD_PERIOD_MS * 1000 / TICK_US;
  localparam int RST_SHORT_TICKS = RST_SHORT_MS * 1000 / TICK_US;
  localparam int RST_LONG_TICKS = RST_LONG_MS * 1000 / TICK_US;
  localparam int CNT_W = 16;

  // Main sequence, Gray along hold, run, pulse
  typedef enum logic [1:0] {
    SVW_HOLD = 2'h0,
    SVW_RUN = 2'h1,
    SVW_PULSE = 2'h3
  } svw_state_t;

  // Pin-level inputs from comparators and the processor
  typedef struct packed {
    logic supply_low;
    logic pf_below;
    logic main_above_batt;
    logic kick;
    logic kick_float;
    logic cs_in_n;
  } svw_pins_t;

  localparam int PINS_W = $bits(svw_pins_t);
  localparam svw_pins_t PINS_RESET = '{supply_low: 1'h1, default: 1'h0};

  // Registered status outputs
  typedef struct packed {
    logic reset_n;
    logic wd_expired_n;
    logic pf_warn_n;
    logic backup_n;
    logic cs_out_n;
  } svw_outs_t;

  localparam svw_outs_t OUTS_RESET = '{reset_n: 1'h0, default: 1'h1};

  // Whole state of the core
  typedef struct packed {
    svw_state_t st;
    logic [CNT_W-1:0] wd_cnt;
    logic [CNT_W-1:0] rst_cnt;
    logic kick_prev;
    logic expired;
    svw_outs_t outs;
  } svw_core_t;

  localparam svw_core_t CORE_RESET = '{
    st: SVW_HOLD,
    wd_cnt: 16'h0000,
    rst_cnt: 16'h0000,
    kick_prev: 1'h0,
    expired: 1'h0,
    outs: OUTS_RESET
  };

endpackage : svw_pkg

// file: src/svw_sync.sv
`timescale 1ns/1ps
module svw_sync import svw_pkg::*; #(
  parameter int W = PINS_W
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } svw_sync_st_t;

  svw_sync_st_t r;
  svw_sync_st_t next_r;

  // First stage is read only by the second
  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      r <= '0;
    end else if (CE) begin
      r <= next_r;
    end
  end

  assign q = r.s2;

endmodule : svw_sync

// file: src/svw_timebase.sv
`timescale 1ns/1ps
module svw_timebase import svw_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic cap_in,
  input wire logic source_sel,
  output logic tick
);

  typedef struct packed {
    logic sel1;
    logic sel2;
    logic cap1;
    logic cap2;
    logic cap_prev;
    logic [PRE_W-1:0] pre;
    logic tick;
  } svw_tb_t;

  svw_tb_t r;
  svw_tb_t next_r;
  logic int_tick;

  // Internal prescaler always runs so a source switch takes effect at once
  always_comb begin
    next_r = r;
    next_r.sel1 = source_sel;
    next_r.sel2 = r.sel1;
    next_r.cap1 = cap_in;
    next_r.cap2 = r.cap1;
    next_r.cap_prev = r.cap2;
    int_tick = (r.pre == PRE_W'(TICK_CYC - 1));
    next_r.pre = int_tick ? '0 : r.pre + PRE_W'(1);
    // Select high or open picks the internal oscillator
    next_r.tick = r.sel2 ? int_tick : (r.cap2 & ~r.cap_prev);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      r <= '{sel1: 1'h1, sel2: 1'h1, default: '0};
    end else if (CE) begin
      r <= next_r;
    end
  end

  assign tick = r.tick;

endmodule : svw_timebase

// file: src/svw_supervisor.sv
`timescale 1ns/1ps
// How it works
// - Period without kick edge gives a reset pulse of 50 or 200 ms.
// - Reset pulses repeat each period until a new kick edge is seen.
// - Floating kick input disables watchdog resets and timeout indication.
// - Timeout output goes low when the period elapses without kick.
// - Timeout output stays low until a kick transition is seen or the kick input floats.
// - Internal oscillator gives 1.6 s; capacitor or clock sets period and pulse.
// - Reset held low while supply-low comparison reports low supply.
// - Reset held a further 50 or 200 ms after supply recovers.
// - Active-high reset output is always the inverse of active-low reset.
// - Chip-select output follows chip-select input while supply is good.
// - Chip-select output forced high while supply is below threshold.
// - Power-fail warning low while sensed input is below reference.
// - Backup switch drive low while main supply exceeds battery.
// - Capacitor or external clock sets the power-on reset stretch.
module svw_supervisor import svw_pkg::*; #(
  parameter bit LONG_PULSE = 1'b0,
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int WD_TICKS_P = WD_TICKS
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic SUPPLY_LOW_IN,
  input wire logic POWER_FAIL_SENSE_IN,
  input wire logic MAIN_ABOVE_BATT_IN,
  input wire logic WATCHDOG_KICK_IN,
  input wire logic WATCHDOG_KICK_FLOAT_IN,
  input wire logic CHIP_SELECT_IN_N,
  input wire logic TIMEBASE_CAP_IN,
  input wire logic TIMEBASE_SOURCE_SELECT,
  output logic RESET_OUT_N,
  output logic RESET_OUT,
  output logic WATCHDOG_EXPIRED_N,
  output logic POWER_FAIL_WARN_N,
  output logic BACKUP_SWITCH_DRIVE_N,
  output logic CHIP_SELECT_OUT_N
);

  localparam int RST_TICKS_P = LONG_PULSE ? RST_LONG_TICKS : RST_SHORT_TICKS;
  localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WD_TICKS_P - 1);
  localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_TICKS_P - 1);

  svw_pins_t pins_raw;
  svw_pins_t pins;
  logic [PINS_W-1:0] pins_q;
  logic tick;
  logic kick_edge;
  logic wd_due;
  logic rst_due;
  svw_core_t r;
  svw_core_t next_r;

  // Every pin crosses two flops before use
  assign pins_raw = '{
    supply_low: SUPPLY_LOW_IN,
    pf_below: POWER_FAIL_SENSE_IN,
    main_above_batt: MAIN_ABOVE_BATT_IN,
    kick: WATCHDOG_KICK_IN,
    kick_float: WATCHDOG_KICK_FLOAT_IN,
    cs_in_n: CHIP_SELECT_IN_N
  };

  svw_sync #(
    .W(PINS_W)
  ) u_sync (
    .CLK(CLK),
    .RESET(RESET),
    .CE(CE),
    .d(pins_raw ^ PINS_RESET),
    .q(pins_q)
  );

  // Stored relative to the reset pattern, so a cleared synchroniser reads as low supply;
  // chip select stays blocked until the real comparator levels have come through
  assign pins = svw_pins_t'(pins_q ^ PINS_RESET);

  // One tick drives all periods, whichever source is chosen
  svw_timebase #(
    .TICK_CYC(TICK_CYC)
  ) u_timebase (
    .CLK(CLK),
    .RESET(RESET),
    .CE(CE),
    .cap_in(TIMEBASE_CAP_IN),
    .source_sel(TIMEBASE_SOURCE_SELECT),
    .tick(tick)
  );

  // Either direction of kick counts as service
  assign kick_edge = pins.kick ^ r.kick_prev;
  assign wd_due = tick && (r.wd_cnt == WD_LAST);
  assign rst_due = tick && (r.rst_cnt == RST_LAST);

  // Main sequence: power hold, run, watchdog pulse
  always_comb begin
    next_r = r;
    next_r.kick_prev = pins.kick;
    case (r.st)
      SVW_HOLD: begin
        // Period parked while held, so a fresh run starts with a full period
        next_r.wd_cnt = '0;
        if (tick) begin
          next_r.rst_cnt = r.rst_cnt + CNT_W'(1);
        end
        if (rst_due) begin
          next_r.st = SVW_RUN;
          next_r.rst_cnt = '0;
        end
      end
      SVW_RUN: begin
        if (tick) begin
          next_r.wd_cnt = r.wd_cnt + CNT_W'(1);
        end
        if (pins.kick_float || kick_edge) begin
          next_r.wd_cnt = '0;
        end else if (wd_due) begin
          next_r.st = SVW_PULSE;
          next_r.expired = 1'b1;
          next_r.wd_cnt = '0;
          next_r.rst_cnt = '0;
        end
      end
      SVW_PULSE: begin
        // Period keeps running so the next pulse is one period after this one
        if (tick) begin
          next_r.wd_cnt = r.wd_cnt + CNT_W'(1);
          next_r.rst_cnt = r.rst_cnt + CNT_W'(1);
        end
        if (pins.kick_float || kick_edge) begin
          next_r.wd_cnt = '0;
        end
        if (rst_due) begin
          next_r.st = SVW_RUN;
          next_r.rst_cnt = '0;
        end
      end
      default: begin
        // Unused code falls back to a held reset, the safe side
        next_r.st = SVW_HOLD;
        next_r.rst_cnt = '0;
      end
    endcase
    // Kick edge or open kick pin releases the timeout flag
    if (kick_edge || pins.kick_float) begin
      next_r.expired = 1'b0;
    end
    // Low supply overrides the sequence and its counts and restarts the stretch; the timeout flag keeps its value
    if (pins.supply_low) begin
      next_r.st = SVW_HOLD;
      next_r.rst_cnt = '0;
      next_r.wd_cnt = '0;
    end
    next_r.outs.reset_n = (next_r.st == SVW_RUN);
    next_r.outs.wd_expired_n = ~next_r.expired;
    next_r.outs.pf_warn_n = ~pins.pf_below;
    next_r.outs.backup_n = ~pins.main_above_batt;
    // Write gate adds the sync delay; a fast analog gate would not
    next_r.outs.cs_out_n = pins.supply_low | pins.cs_in_n;
  end

  // Reset wins over the clock enable
  always_ff @(posedge CLK) begin
    if (RESET) begin
      r <= CORE_RESET;
    end else if (CE) begin
      r <= next_r;
    end
  end

  // Outputs straight from flops; high reset is the exact inverse
  assign RESET_OUT_N = r.outs.reset_n;
  assign RESET_OUT = ~r.outs.reset_n;
  assign WATCHDOG_EXPIRED_N = r.outs.wd_expired_n;
  assign POWER_FAIL_WARN_N = r.outs.pf_warn_n;
  assign BACKUP_SWITCH_DRIVE_N = r.outs.backup_n;
  assign CHIP_SELECT_OUT_N = r.outs.cs_out_n;

  // Checks run on the core clock; synchronous reset silences them
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  sequence hold_done_s;
    CE && r.st == SVW_HOLD && rst_due && !pins.supply_low;
  endsequence

  sequence wd_miss_s;
    CE && r.st == SVW_RUN && wd_due && !kick_edge && !pins.kick_float
      && !pins.supply_low;
  endsequence

  sequence pulse_start_s;
    CE && r.st == SVW_RUN ##1 r.st == SVW_PULSE;
  endsequence

  sequence pulse_end_s;
    CE && r.st == SVW_PULSE && rst_due && !pins.supply_low;
  endsequence

  sequence pulse_mid_s;
    CE && r.st == SVW_PULSE && !rst_due && !pins.supply_low;
  endsequence

  // Reset, chip select and status levels
  reset_inverse_a: assert property (RESET_OUT == !RESET_OUT_N)
    else $error("active-high reset is not the inverse");

  supply_hold_a: assert property (CE && pins.supply_low |=> !RESET_OUT_N)
    else $error("reset released while supply low");

  stretch_end_a: assert property (hold_done_s |=> RESET_OUT_N && r.st == SVW_RUN)
    else $error("reset not released after stretch");

  stretch_hold_a: assert property (CE && r.st == SVW_HOLD && !rst_due |=> !RESET_OUT_N)
    else $error("reset released before stretch end");

  cs_block_a: assert property (CE && pins.supply_low |=> CHIP_SELECT_OUT_N)
    else $error("chip select not blocked on low supply");

  cs_follow_a: assert property (CE && !pins.supply_low
      |=> CHIP_SELECT_OUT_N == $past(pins.cs_in_n))
    else $error("chip select does not follow input");

  pfail_warn_a: assert property (CE |=> POWER_FAIL_WARN_N == !$past(pins.pf_below))
    else $error("power-fail warning wrong");

  backup_drive_a: assert property (CE
      |=> BACKUP_SWITCH_DRIVE_N == !$past(pins.main_above_batt))
    else $error("backup switch drive wrong");

  wd_expire_a: assert property (wd_miss_s
      |=> !WATCHDOG_EXPIRED_N && !RESET_OUT_N && r.wd_cnt == 0)
    else $error("missed kick did not raise timeout and reset");

  float_quiet_a: assert property (CE && pins.kick_float |=> WATCHDOG_EXPIRED_N)
    else $error("timeout shown with kick input open");

  expire_hold_a: assert property (!WATCHDOG_EXPIRED_N && CE && !kick_edge
      && !pins.kick_float |=> !WATCHDOG_EXPIRED_N)
    else $error("timeout released without kick");

  kick_restart_a: assert property (CE && kick_edge && !pins.kick_float
      && r.st == SVW_RUN && !pins.supply_low |=> r.wd_cnt == 0 && WATCHDOG_EXPIRED_N)
    else $error("kick did not restart period");

  pulse_restart_a: assert property (pulse_start_s |-> r.wd_cnt == 0 && r.rst_cnt == 0)
    else $error("watchdog pulse did not restart period");

  // Pulse width is set by its own count; a kick clears the timeout but not the pulse
  pulse_end_a: assert property (pulse_end_s |=> RESET_OUT_N && r.st == SVW_RUN)
    else $error("watchdog pulse did not end on its count");

  pulse_hold_a: assert property (pulse_mid_s |=> !RESET_OUT_N && r.st == SVW_PULSE)
    else $error("watchdog pulse ended early");

  reset_run_a: assert property (CE && r.st == SVW_RUN && !wd_due
      && !pins.supply_low |=> RESET_OUT_N)
    else $error("reset asserted while running");

  // Timeout output moves only on a missed period, on service or on an open kick pin
  expire_quiet_a: assert property (CE && WATCHDOG_EXPIRED_N && !wd_due
      |=> WATCHDOG_EXPIRED_N)
    else $error("timeout raised without a missed period");

  kick_release_a: assert property (CE && !WATCHDOG_EXPIRED_N && kick_edge
      |=> WATCHDOG_EXPIRED_N)
    else $error("kick did not release timeout");

  float_no_pulse_a: assert property (CE && pins.kick_float && r.st == SVW_RUN
      && !pins.supply_low |=> r.st == SVW_RUN && r.wd_cnt == 0)
    else $error("watchdog ran with kick input open");

  // Counters move only on a tick, so any timebase scales every period alike
  no_early_pulse_a: assert property (CE && r.st == SVW_RUN && !tick |=> r.st != SVW_PULSE)
    else $error("watchdog pulse started without a tick");

  wd_still_a: assert property (CE && r.st == SVW_RUN && !tick && !kick_edge
      && !pins.kick_float && !pins.supply_low |=> r.wd_cnt == $past(r.wd_cnt))
    else $error("watchdog count moved without a tick");

  wd_step_a: assert property (CE && r.st == SVW_RUN && tick && !wd_due
      && !kick_edge && !pins.kick_float && !pins.supply_low
      |=> r.wd_cnt == $past(r.wd_cnt) + 1)
    else $error("watchdog count missed a tick");

  stretch_step_a: assert property (CE && r.st == SVW_HOLD && tick && !rst_due
      && !pins.supply_low |=> r.rst_cnt == $past(r.rst_cnt) + 1)
    else $error("stretch count missed a tick");

  supply_restart_a: assert property (CE && pins.supply_low
      |=> r.st == SVW_HOLD && r.rst_cnt == 0 && r.wd_cnt == 0)
    else $error("low supply did not restart the stretch");

  // A frozen enable must hold the reset, timeout, chip-select and power-fail outputs where they stand
  freeze_hold_a: assert property (!CE
      |=> $stable(RESET_OUT_N) && $stable(WATCHDOG_EXPIRED_N)
      && $stable(CHIP_SELECT_OUT_N) && $stable(POWER_FAIL_WARN_N))
    else $error("outputs moved while the enable was low");

endmodule : svw_supervisor

// file: bench/svw_cpu_model.sv
`timescale 1ns/1ps
// Processor side: a software loop that toggles its I/O line while running
module svw_cpu_model #(
  parameter int HALF = 40
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  output logic kick
);
  int cnt;
  initial begin
    kick = 1'b0;
    cnt = 0;
  end
  // Toggle well inside the period; a CPU held in reset or hung keeps the line still
  always @(negedge clk) begin
    if (reset_n && run) begin
      if (cnt == HALF - 1) begin
        kick <= ~kick;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : svw_cpu_model

// file: bench/tb_supervisor_reset_watchdog.sv
`timescale 1ns/1ps
module tb_supervisor_reset_watchdog;
  localparam int TC = 4;
  localparam int WDT = 80;
  localparam int RT = svw_pkg::RST_SHORT_TICKS;
  logic clk, reset, supply, pf, mab, kick, flt, cs_in_n, cap, src, run, ce;
  logic rst_n, rst, wdo_n, pfo_n, batt_n, cs_out_n, bad;
  int n_fail = 0;
  int n_compared = 0;
  int cdiv = 0;
  int n, m;

  svw_supervisor #(.LONG_PULSE(1'b0), .TICK_CYC(TC), .WD_TICKS_P(WDT)) i_dut (
    .CLK(clk), .RESET(reset), .CE(ce), .SUPPLY_LOW_IN(supply), .POWER_FAIL_SENSE_IN(pf),
    .MAIN_ABOVE_BATT_IN(mab), .WATCHDOG_KICK_IN(kick), .WATCHDOG_KICK_FLOAT_IN(flt),
    .CHIP_SELECT_IN_N(cs_in_n), .TIMEBASE_CAP_IN(cap), .TIMEBASE_SOURCE_SELECT(src),
    .RESET_OUT_N(rst_n), .RESET_OUT(rst), .WATCHDOG_EXPIRED_N(wdo_n),
    .POWER_FAIL_WARN_N(pfo_n), .BACKUP_SWITCH_DRIVE_N(batt_n), .CHIP_SELECT_OUT_N(cs_out_n));
  svw_cpu_model #(.HALF(40)) i_cpu (.clk(clk), .reset_n(rst_n), .run(run), .kick(kick));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Free-running external timebase, one rising edge every 10 cycles
  always @(negedge clk) begin
    cdiv <= (cdiv == 4) ? 0 : cdiv + 1;
    if (cdiv == 4) cap <= ~cap;
  end

  task automatic check(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  // Bounded wait for the reset output to reach a level, returns cycles spent
  task automatic wait_rst(input logic lvl, input int lim, output int k);
    k = 0;
    while (rst_n !== lvl && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_rst
  // Tick phase and the sync stages blur each edge by a few cycles
  function automatic logic near(input int v, input int exp, input int tc);
    return (v >= exp - tc - 2) && (v <= exp + 2 * tc + 4);
  endfunction : near
  task automatic quiet(input int k, output logic b);
    b = 1'b0;
    repeat (k) begin
      @(negedge clk);
      if (rst_n !== 1'b1 || wdo_n !== 1'b1) b = 1'b1;
    end
  endtask : quiet

  task automatic t_power_on();
    check(rst_n, 1'b0);
    wait_rst(1'b1, 400, n);
    check(near(n, RT * TC, TC), 1'b1);
    check(rst, 1'b0);
    $display("test power_on done");
  endtask : t_power_on

  task automatic t_supply();
    cs_in_n = 1'b0;
    cyc(5);
    check(cs_out_n, 1'b0);
    cs_in_n = 1'b1;
    cyc(5);
    check(cs_out_n, 1'b1);
    cs_in_n = 1'b0;
    supply = 1'b1;
    cyc(5);
    check(rst_n, 1'b0);
    check(cs_out_n, 1'b1);
    cyc(300);
    check(rst_n, 1'b0);
    check(rst, 1'b1);
    // A short dropout in mid-stretch must start the stretch again
    supply = 1'b0;
    cyc(100);
    supply = 1'b1;
    cyc(10);
    supply = 1'b0;
    wait_rst(1'b1, 400, n);
    check(near(n, RT * TC, TC), 1'b1);
    check(cs_out_n, 1'b0);
    $display("test supply done");
  endtask : t_supply

  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      pf = i[0];
      mab = i[1];
      cyc(5);
      check(pfo_n, ~i[0]);
      check(batt_n, ~i[1]);
    end
    $display("test status done");
  endtask : t_status

  // Low enable holds the outputs; the new pin levels come through once it returns
  task automatic t_freeze();
    ce = 1'b0;
    pf = 1'b0;
    mab = 1'b0;
    cyc(10);
    check(pfo_n, 1'b0);
    check(batt_n, 1'b0);
    ce = 1'b1;
    cyc(5);
    check(pfo_n, 1'b1);
    check(batt_n, 1'b1);
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_kicked();
    quiet(1000, bad);
    check(bad, 1'b0);
    flt = 1'b1;
    run = 1'b0;
    quiet(WDT * TC * 3, bad);
    check(bad, 1'b0);
    flt = 1'b0;
    run = 1'b1;
    cyc(50);
    $display("test kicked_float done");
  endtask : t_kicked

  // Hung processor: timeout, pulse width, repeat spacing, release by kick
  task automatic t_expire(input int tc);
    @(kick);
    @(negedge clk);
    run = 1'b0;
    wait_rst(1'b0, WDT * tc + 40, n);
    check(near(n, WDT * tc, tc), 1'b1);
    check(wdo_n, 1'b0);
    check(rst, 1'b1);
    wait_rst(1'b1, RT * tc + 40, n);
    check(near(n, RT * tc, 1), 1'b1);
    check(wdo_n, 1'b0);
    wait_rst(1'b0, WDT * tc, m);
    check(near(n + m, WDT * tc, 1), 1'b1);
    check(rst_n, 1'b0);
    wait_rst(1'b1, RT * tc + 40, n);
    run = 1'b1;
    cyc(50);
    check(wdo_n, 1'b1);
    quiet(400, bad);
    check(bad, 1'b0);
    $display("test expire tc=%0d done", tc);
  endtask : t_expire

  task automatic t_external();
    src = 1'b0;
    cyc(20);
    t_expire(10);
    supply = 1'b1;
    cyc(10);
    supply = 1'b0;
    wait_rst(1'b1, 1000, n);
    check(near(n, RT * 10, 10), 1'b1);
    $display("test external done");
  endtask : t_external

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // Run takes about 7300 cycles; cut it short well beyond that
  initial begin
    #400000;
    n_fail++;
    results();
  end

  initial begin
    reset = 1'b1;
    {supply, pf, mab, flt, cap} = 5'h00;
    cs_in_n = 1'b1;
    ce = 1'b1;
    src = 1'b1;
    run = 1'b1;
    cyc(6);
    reset = 1'b0;
    t_power_on();
    t_supply();
    t_status();
    t_freeze();
    t_kicked();
    t_expire(TC);
    t_external();
    results();
  end
endmodule : tb_supervisor_reset_watchdog
